/* File: core/arb_if.sv */
`timescale 1ns/100ps
interface arb_if #(
	parameter int N = 81,
	parameter int RW = 5,
	parameter int IW = 7
);
	logic [N-1:0] req;
	logic [N-1:0][RW-1:0] rank;
	logic win_valid;
	logic [IW-1:0] win_index;
	logic [RW-1:0] win_rank;

	modport source (output req, output rank, input win_valid, input win_index, input win_rank);
	modport arbiter (input req, input rank, output win_valid, output win_index, output win_rank);
endinterface

/* File: core/channel_mapper.sv */
`timescale 1ns/100ps
module channel_mapper (
	// peripheral sources
	input wire logic [vim_pkg::CHANNELS-1:0] single_in,
	input wire logic [15:0] external_line_request_in,
	input wire logic [6:0] first_dma_controller_in,
	input wire logic [4:0] second_dma_controller_in,
	input wire logic [1:0] first_second_converters_in,
	input wire logic [1:0] first_usb_device_in,
	input wire logic [3:0] first_can_controller_in,
	input wire logic [3:0] first_advanced_timer_in,
	input wire logic [3:0] second_advanced_timer_in,
	input wire logic [1:0] second_usb_device_in,
	input wire logic [3:0] second_can_controller_in,
	// channel requests
	output logic [vim_pkg::CHANNELS-1:0] chan_req_out
);
	always_comb begin
		chan_req_out = single_in & vim_pkg::SINGLE_CHANNEL_MASK;
		for (int i = 0; i < vim_pkg::CH_EXT_DIRECT; i++) begin
			chan_req_out[vim_pkg::CH_EXT_FIRST + i] = external_line_request_in[i]; // R05
		end
		for (int i = 0; i < vim_pkg::DMA_A_CHANNELS; i++) begin
			chan_req_out[vim_pkg::CH_DMA_A_FIRST + i] = first_dma_controller_in[i]; // R08
		end
		chan_req_out[vim_pkg::CH_CONVERTERS] = |first_second_converters_in; // R09
		chan_req_out[vim_pkg::CH_USB_HP_CAN_TX] = first_usb_device_in[vim_pkg::USB_HP] |
			first_can_controller_in[vim_pkg::CAN_TX]; // R10
		chan_req_out[vim_pkg::CH_USB_LP_CAN_RX0] = first_usb_device_in[vim_pkg::USB_LP] |
			first_can_controller_in[vim_pkg::CAN_RX0]; // R11
		chan_req_out[vim_pkg::CH_CAN_A_RX1] = first_can_controller_in[vim_pkg::CAN_RX1]; // R12
		chan_req_out[vim_pkg::CH_CAN_A_STATUS] = first_can_controller_in[vim_pkg::CAN_STATUS]; // R12
		// shared lines: software must read the line pending flags to find the source
		chan_req_out[vim_pkg::CH_EXT_MID] =
			|external_line_request_in[vim_pkg::EXT_MID_HIGH:vim_pkg::EXT_MID_LOW]; // R06
		chan_req_out[vim_pkg::CH_EXT_HIGH] =
			|external_line_request_in[vim_pkg::EXT_HIGH_HIGH:vim_pkg::EXT_HIGH_LOW]; // R07
		for (int i = 0; i < vim_pkg::TIMER_LINES; i++) begin
			chan_req_out[vim_pkg::CH_TIM1_FIRST + i] = first_advanced_timer_in[i]; // R13
			chan_req_out[vim_pkg::CH_TIM2_FIRST + i] = second_advanced_timer_in[i]; // R14
		end
		for (int i = 0; i < vim_pkg::DMA_B_DIRECT; i++) begin
			chan_req_out[vim_pkg::CH_DMA_B_FIRST + i] = second_dma_controller_in[i]; // R15
		end
		chan_req_out[vim_pkg::CH_DMA_B_SHARED] = |second_dma_controller_in[4:3]; // R15
		chan_req_out[vim_pkg::CH_RESERVED] = 1'b0; // R15
		chan_req_out[vim_pkg::CH_USB_B_HP_CAN_B_TX] = second_usb_device_in[vim_pkg::USB_HP] |
			second_can_controller_in[vim_pkg::CAN_TX];
		chan_req_out[vim_pkg::CH_USB_B_LP_CAN_B_RX0] = second_usb_device_in[vim_pkg::USB_LP] |
			second_can_controller_in[vim_pkg::CAN_RX0];
		chan_req_out[vim_pkg::CH_CAN_B_RX1] = second_can_controller_in[vim_pkg::CAN_RX1]; // R16
		chan_req_out[vim_pkg::CH_CAN_B_STATUS] = second_can_controller_in[vim_pkg::CAN_STATUS]; // R16
	end
endmodule

/* File: core/priority_arbiter.sv */
`timescale 1ns/100ps
module priority_arbiter #(
	parameter int ENTRIES = 81,
	parameter int RANK_W = 5,
	parameter int IDX_W = 7
) (
	arb_if.arbiter bus
);
	logic found;
	logic [IDX_W-1:0] best_index;
	logic [RANK_W-1:0] best_rank;

	// strict compare in ascending order: on equal rank the lower slot stays
	always_comb begin
		found = 1'b0;
		best_index = '0;
		best_rank = '1;
		for (int i = 0; i < ENTRIES; i++) begin
			if (bus.req[i] && (!found || bus.rank[i] < best_rank)) begin // R18
				found = 1'b1;
				best_index = IDX_W'(i);
				best_rank = bus.rank[i];
			end
		end
	end

	assign bus.win_valid = found;
	assign bus.win_index = best_index;
	assign bus.win_rank = best_rank;
endmodule

/* File: core/vectored_interrupt_mapper.sv */
// Behaviour
// [R01] 65 maskable channels numbered from zero, after 16 core exception slots.
// [R02] each channel and settable core exception has a 4-bit priority, 16 levels.
// [R03] reset, nmi, hard fault fixed at -3, -2, -1, above all programmed levels.
// [R04] channel n vector word sits at 0x40 plus four times n.
// [R05] external lines 0..4 have own channels 6..10 in order.
// [R06] external lines 5..9 share channel 23.
// [R07] external lines 10..15 share channel 40.
// [R08] first dma controller channels 1..7 map to channels 11..17.
// [R09] both converters share channel 18.
// [R10] usb high-priority and can transmit share channel 19.
// [R11] usb low-priority and can receive fifo 0 share channel 20.
// [R12] first can: receive fifo 1 on 21, status change/error on 22.
// [R13] first advanced timer: break 24, update 25, trigger 26, compare 27.
// [R14] second advanced timer: break 43, update 44, trigger 45, compare 46.
// [R15] second dma: 1..3 on 56..58, 4 and 5 on 59, 60 reserved.
// [R16] second can: receive fifo 1 on 63, status change/error on 64.
// [R17] entry is presented to the core with low, fixed latency.
// [R18] equal programmed priority: lower channel number is served first.
`timescale 1ns/100ps
module vectored_interrupt_mapper (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// core exceptions
	input wire logic NMI_IN,
	input wire logic HARD_FAULT_IN,
	input wire logic [vim_pkg::SETTABLE-1:0] SYS_REQ_IN,
	input wire logic [vim_pkg::SETTABLE*vim_pkg::PRIO_W-1:0] SYS_PRIORITY_IN,
	// channel configuration
	input wire logic [vim_pkg::CHANNELS-1:0] CH_ENABLE_IN,
	input wire logic [vim_pkg::CHANNELS*vim_pkg::PRIO_W-1:0] CH_PRIORITY_IN,
	// peripheral requests
	input wire logic [vim_pkg::CHANNELS-1:0] SINGLE_REQ_IN,
	input wire logic [15:0] EXTERNAL_LINE_REQUEST_IN,
	input wire logic [6:0] FIRST_DMA_CONTROLLER_IN,
	input wire logic [4:0] SECOND_DMA_CONTROLLER_IN,
	input wire logic [1:0] FIRST_SECOND_CONVERTERS_IN,
	input wire logic [1:0] FIRST_USB_DEVICE_IN,
	input wire logic [3:0] FIRST_CAN_CONTROLLER_IN,
	input wire logic [3:0] FIRST_ADVANCED_TIMER_IN,
	input wire logic [3:0] SECOND_ADVANCED_TIMER_IN,
	input wire logic [1:0] SECOND_USB_DEVICE_IN,
	input wire logic [3:0] SECOND_CAN_CONTROLLER_IN,
	// core entry handshake
	input wire logic ACK_IN,
	output logic REQUEST_VALID_OUT,
	output logic [vim_pkg::IDX_W-1:0] EXCEPTION_NUMBER_OUT,
	output logic [31:0] VECTOR_ADDRESS_OUT,
	output logic [vim_pkg::RANK_W-1:0] PRIORITY_RANK_OUT
);
	localparam int N = vim_pkg::ENTRIES;
	localparam int CL = vim_pkg::CORE_LINES;

	logic rst_meta;
	logic rst_n;
	logic [vim_pkg::CHANNELS-1:0] chan_req;
	logic [N-1:0] pend;
	logic [N-1:0] next_pend;
	logic [N-1:0] set_vec;
	logic [N-1:0] ack_clear;
	logic [N-1:0] enable_vec;
	logic next_valid;
	logic [vim_pkg::IDX_W-1:0] next_exc;
	logic [31:0] next_addr;
	logic [vim_pkg::RANK_W-1:0] next_rank;

	arb_if #(.N(N), .RW(vim_pkg::RANK_W), .IW(vim_pkg::IDX_W)) arb ();

	// reset released through two flops
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	channel_mapper u_mapper (
		.single_in(SINGLE_REQ_IN),
		.external_line_request_in(EXTERNAL_LINE_REQUEST_IN),
		.first_dma_controller_in(FIRST_DMA_CONTROLLER_IN),
		.second_dma_controller_in(SECOND_DMA_CONTROLLER_IN),
		.first_second_converters_in(FIRST_SECOND_CONVERTERS_IN),
		.first_usb_device_in(FIRST_USB_DEVICE_IN),
		.first_can_controller_in(FIRST_CAN_CONTROLLER_IN),
		.first_advanced_timer_in(FIRST_ADVANCED_TIMER_IN),
		.second_advanced_timer_in(SECOND_ADVANCED_TIMER_IN),
		.second_usb_device_in(SECOND_USB_DEVICE_IN),
		.second_can_controller_in(SECOND_CAN_CONTROLLER_IN),
		.chan_req_out(chan_req)
	);

	// pending state: sources set, the core's acknowledge clears; set wins
	always_comb begin
		set_vec = '0;
		set_vec[vim_pkg::EXC_NMI] = NMI_IN;
		set_vec[vim_pkg::EXC_HARD_FAULT] = HARD_FAULT_IN;
		for (int i = 0; i < vim_pkg::SETTABLE; i++) begin
			set_vec[vim_pkg::SETTABLE_EXC[i]] = SYS_REQ_IN[i];
		end
		set_vec[N-1:CL] = chan_req; // R01
		ack_clear = '0;
		if (ACK_IN && REQUEST_VALID_OUT) begin
			ack_clear[EXCEPTION_NUMBER_OUT] = 1'b1;
		end
		next_pend = (pend & ~ack_clear) | set_vec;
	end

	// reset slot comes up pending so the reset vector is presented first
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			pend <= {{(N-2){1'b0}}, 2'b10};
		end else begin
			pend <= next_pend;
		end
	end

	// ranks: fixed ones below every programmed level
	always_comb begin
		enable_vec = '1;
		enable_vec[N-1:CL] = CH_ENABLE_IN;
		for (int i = 0; i < N; i++) begin
			arb.rank[i] = '1;
		end
		arb.rank[vim_pkg::EXC_RESET] = vim_pkg::RANK_RESET; // R03
		arb.rank[vim_pkg::EXC_NMI] = vim_pkg::RANK_NMI; // R03
		arb.rank[vim_pkg::EXC_HARD_FAULT] = vim_pkg::RANK_HARD_FAULT; // R03
		for (int i = 0; i < vim_pkg::SETTABLE; i++) begin
			arb.rank[vim_pkg::SETTABLE_EXC[i]] = vim_pkg::RANK_OFFSET +
				{1'b0, SYS_PRIORITY_IN[i*vim_pkg::PRIO_W +: vim_pkg::PRIO_W]}; // R02
		end
		for (int i = 0; i < vim_pkg::CHANNELS; i++) begin
			arb.rank[CL + i] = vim_pkg::RANK_OFFSET +
				{1'b0, CH_PRIORITY_IN[i*vim_pkg::PRIO_W +: vim_pkg::PRIO_W]}; // R02
		end
		// the slot being taken this cycle drops out at once, avoiding a double entry
		arb.req = pend & enable_vec & ~ack_clear;
	end

	priority_arbiter #(
		.ENTRIES(N),
		.RANK_W(vim_pkg::RANK_W),
		.IDX_W(vim_pkg::IDX_W)
	) u_arbiter (
		.bus(arb)
	);

	// presented winner, one register stage behind the pending state
	always_comb begin
		next_valid = arb.win_valid; // R17
		next_exc = arb.win_index;
		next_rank = arb.win_rank;
		next_addr = vim_pkg::vector_address(arb.win_index); // R04
		if (!arb.win_valid) begin
			next_exc = '0;
			next_rank = '0;
			next_addr = '0;
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			REQUEST_VALID_OUT <= 1'b0;
			EXCEPTION_NUMBER_OUT <= '0;
			VECTOR_ADDRESS_OUT <= '0;
			PRIORITY_RANK_OUT <= '0;
		end else begin
			REQUEST_VALID_OUT <= next_valid;
			EXCEPTION_NUMBER_OUT <= next_exc;
			VECTOR_ADDRESS_OUT <= next_addr;
			PRIORITY_RANK_OUT <= next_rank;
		end
	end

	a_slot_range: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R01
		REQUEST_VALID_OUT |-> EXCEPTION_NUMBER_OUT < vim_pkg::IDX_W'(N))
		else $error("presented slot beyond channel 64");

	a_prog_level: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R02
		(arb.req[CL] && arb.req[CL-1:0] == '0 && arb.req[N-1:CL+1] == '0) |=>
		(EXCEPTION_NUMBER_OUT == vim_pkg::IDX_W'(CL) &&
		PRIORITY_RANK_OUT == vim_pkg::RANK_OFFSET +
		{1'b0, $past(CH_PRIORITY_IN[vim_pkg::PRIO_W-1:0])}))
		else $error("channel 0 rank not its programmed level");

	a_nmi_fixed: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R03
		(arb.req[vim_pkg::EXC_NMI] && !arb.req[vim_pkg::EXC_RESET]) |=>
		(REQUEST_VALID_OUT && EXCEPTION_NUMBER_OUT == vim_pkg::EXC_NMI))
		else $error("nmi lost to a lower level");

	a_vector_addr: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R04
		(REQUEST_VALID_OUT && EXCEPTION_NUMBER_OUT >= vim_pkg::IDX_W'(CL)) |->
		VECTOR_ADDRESS_OUT == vim_pkg::CHANNEL_TABLE_BASE +
		{23'h0, EXCEPTION_NUMBER_OUT - vim_pkg::IDX_W'(CL), 2'b00})
		else $error("channel vector address wrong");

	a_ext_direct: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R05
		EXTERNAL_LINE_REQUEST_IN[4] |=> pend[CL + vim_pkg::CH_EXT_FIRST + 4])
		else $error("external line 4 not pending on channel 10");

	a_ext_mid: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R06
		$rose(EXTERNAL_LINE_REQUEST_IN[7]) |=> pend[CL + vim_pkg::CH_EXT_MID])
		else $error("external line 7 not on channel 23");

	a_ext_high: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R07
		EXTERNAL_LINE_REQUEST_IN[15] |=> pend[CL + vim_pkg::CH_EXT_HIGH])
		else $error("external line 15 not on channel 40");

	a_dma_first: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R08
		FIRST_DMA_CONTROLLER_IN[6] |=> pend[CL + vim_pkg::CH_DMA_A_FIRST + 6])
		else $error("first dma channel 7 not on channel 17");

	a_converters: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R09
		FIRST_SECOND_CONVERTERS_IN[1] |=> pend[CL + vim_pkg::CH_CONVERTERS])
		else $error("second converter not on channel 18");

	a_usb_can_hp: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R10
		FIRST_CAN_CONTROLLER_IN[vim_pkg::CAN_TX] |=> pend[CL + vim_pkg::CH_USB_HP_CAN_TX])
		else $error("can transmit not on channel 19");

	a_usb_can_lp: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R11
		FIRST_USB_DEVICE_IN[vim_pkg::USB_LP] |=> pend[CL + vim_pkg::CH_USB_LP_CAN_RX0])
		else $error("usb low priority not on channel 20");

	a_can_status: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R12
		FIRST_CAN_CONTROLLER_IN[vim_pkg::CAN_STATUS] |=> pend[CL + vim_pkg::CH_CAN_A_STATUS])
		else $error("can status change not on channel 22");

	a_timer_map: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R13
		FIRST_ADVANCED_TIMER_IN[3] |=> pend[CL + vim_pkg::CH_TIM1_FIRST + 3])
		else $error("timer compare not on channel 27");

	a_timer2_map: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R14
		SECOND_ADVANCED_TIMER_IN[0] |=> pend[CL + vim_pkg::CH_TIM2_FIRST])
		else $error("second timer break not on channel 43");

	a_reserved_idle: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R15
		!pend[CL + vim_pkg::CH_RESERVED] and (SECOND_DMA_CONTROLLER_IN[4] |=>
		pend[CL + vim_pkg::CH_DMA_B_SHARED]))
		else $error("second dma sharing or reserved slot wrong");

	a_can_b_top: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R16
		SECOND_CAN_CONTROLLER_IN[vim_pkg::CAN_STATUS] |=> pend[N-1])
		else $error("second can status change not on channel 64");

	a_entry_latency: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R17
		$rose(SINGLE_REQ_IN[0] && CH_ENABLE_IN[0]) |-> ##2 REQUEST_VALID_OUT)
		else $error("request not presented two cycles after it arrived");

	a_tie_lower: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R18
		(arb.req[CL+1:0] == {2'b11, {CL{1'b0}}} && arb.req[N-1:CL+2] == '0 &&
		arb.rank[CL] == arb.rank[CL+1]) |=> EXCEPTION_NUMBER_OUT == vim_pkg::IDX_W'(CL))
		else $error("tie not broken toward the lower channel");

	a_ack_clears: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R17
		(REQUEST_VALID_OUT && ACK_IN && !set_vec[EXCEPTION_NUMBER_OUT]) |=>
		!pend[$past(EXCEPTION_NUMBER_OUT)])
		else $error("taken entry still pending");

	a_set_wins: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R17
		(REQUEST_VALID_OUT && ACK_IN && set_vec[EXCEPTION_NUMBER_OUT]) |=>
		pend[$past(EXCEPTION_NUMBER_OUT)])
		else $error("new request lost to the acknowledge");

	a_idle_zero: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R04
		!REQUEST_VALID_OUT |-> (EXCEPTION_NUMBER_OUT == '0 && VECTOR_ADDRESS_OUT == '0 &&
		PRIORITY_RANK_OUT == '0))
		else $error("idle outputs not cleared");

	a_core_addr: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R01
		(REQUEST_VALID_OUT && EXCEPTION_NUMBER_OUT < vim_pkg::IDX_W'(CL)) |->
		VECTOR_ADDRESS_OUT == {23'h0, EXCEPTION_NUMBER_OUT, 2'b00})
		else $error("core exception vector address wrong");

	a_can_rx1: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R12
		FIRST_CAN_CONTROLLER_IN[vim_pkg::CAN_RX1] |=> pend[CL + vim_pkg::CH_CAN_A_RX1])
		else $error("can receive fifo 1 not on channel 21");

	a_dma_b_direct: assert property (@(posedge CLK_IN) disable iff (!rst_n) // R15
		SECOND_DMA_CONTROLLER_IN[0] |=> pend[CL + vim_pkg::CH_DMA_B_FIRST])
		else $error("second dma channel 1 not on channel 56");
endmodule

/* File: core/vim_pkg.sv */
package vim_pkg;
	localparam int CHANNELS = 65;
	localparam int CORE_LINES = 16;
	localparam int ENTRIES = CHANNELS + CORE_LINES;
	localparam int IDX_W = 7;
	localparam int PRIO_W = 4;
	localparam int RANK_W = 5;
	localparam int SETTABLE = 7;

	localparam logic [31:0] CHANNEL_TABLE_BASE = 32'h0000_0040;

	// core exception numbers, as table slots
	localparam logic [IDX_W-1:0] EXC_RESET = 7'h01;
	localparam logic [IDX_W-1:0] EXC_NMI = 7'h02;
	localparam logic [IDX_W-1:0] EXC_HARD_FAULT = 7'h03;
	// order: mem manage, bus fault, usage fault, svcall, debug monitor, pendsv, systick
	localparam logic [SETTABLE-1:0][IDX_W-1:0] SETTABLE_EXC =
		{7'h0f, 7'h0e, 7'h0c, 7'h0b, 7'h06, 7'h05, 7'h04};

	// fixed ranks sit below every programmed level; lower rank wins
	localparam logic [RANK_W-1:0] RANK_RESET = 5'h00;
	localparam logic [RANK_W-1:0] RANK_NMI = 5'h01;
	localparam logic [RANK_W-1:0] RANK_HARD_FAULT = 5'h02;
	localparam logic [RANK_W-1:0] RANK_OFFSET = 5'h03;

	// channel numbers
	localparam int CH_EXT_FIRST = 6;
	localparam int CH_EXT_DIRECT = 5;
	localparam int CH_DMA_A_FIRST = 11;
	localparam int DMA_A_CHANNELS = 7;
	localparam int CH_CONVERTERS = 18;
	localparam int CH_USB_HP_CAN_TX = 19;
	localparam int CH_USB_LP_CAN_RX0 = 20;
	localparam int CH_CAN_A_RX1 = 21;
	localparam int CH_CAN_A_STATUS = 22;
	localparam int CH_EXT_MID = 23;
	localparam int CH_TIM1_FIRST = 24;
	localparam int CH_EXT_HIGH = 40;
	localparam int CH_TIM2_FIRST = 43;
	localparam int CH_DMA_B_FIRST = 56;
	localparam int DMA_B_DIRECT = 3;
	localparam int CH_DMA_B_SHARED = 59;
	localparam int CH_RESERVED = 60;
	localparam int CH_USB_B_HP_CAN_B_TX = 61;
	localparam int CH_USB_B_LP_CAN_B_RX0 = 62;
	localparam int CH_CAN_B_RX1 = 63;
	localparam int CH_CAN_B_STATUS = 64;
	localparam int EXT_MID_LOW = 5;
	localparam int EXT_MID_HIGH = 9;
	localparam int EXT_HIGH_LOW = 10;
	localparam int EXT_HIGH_HIGH = 15;
	localparam int TIMER_LINES = 4;

	// channels fed by one source each from the generic request vector
	localparam logic [CHANNELS-1:0] SINGLE_CHANNEL_MASK = 65'h0_00ff86ff_f000003f;

	// can vector bit order: transmit, receive fifo 0, receive fifo 1, status change/error
	localparam int CAN_TX = 0;
	localparam int CAN_RX0 = 1;
	localparam int CAN_RX1 = 2;
	localparam int CAN_STATUS = 3;
	localparam int USB_HP = 0;
	localparam int USB_LP = 1;

	function automatic logic [31:0] vector_address(input logic [IDX_W-1:0] exc);
		logic [31:0] slot;
		slot = {25'h0, exc};
		if (slot >= 32'(CORE_LINES))
			return CHANNEL_TABLE_BASE + ((slot - 32'(CORE_LINES)) << 2);
		return slot << 2;
	endfunction
endpackage

/* File: test/core_entry_model.sv */
`timescale 1ns/100ps
module core_entry_model (
	// clock
	input wire logic clk_in,
	// presented entry
	input wire logic valid_in,
	input wire logic [vim_pkg::IDX_W-1:0] number_in,
	input wire logic [31:0] address_in,
	input wire logic [vim_pkg::RANK_W-1:0] rank_in,
	// answer speed: one less than the edges seen valid before taking
	input wire logic [3:0] delay_in,
	output logic ack_out
);
	logic [vim_pkg::IDX_W-1:0] seen_num[$];
	logic [31:0] seen_addr[$];
	logic [vim_pkg::RANK_W-1:0] seen_rank[$];
	int cnt;

	// at least one quiet edge after each take, so a late update is never taken twice
	initial begin
		ack_out = 1'b0;
		cnt = 0;
		forever begin
			@(posedge clk_in);
			if (ack_out) begin
				seen_num.push_back(number_in);
				seen_addr.push_back(address_in);
				seen_rank.push_back(rank_in);
				cnt = 0;
				#1 ack_out = 1'b0;
			end else if (valid_in) begin
				cnt++;
				if (cnt > int'(delay_in)) begin
					#1 ack_out = 1'b1;
				end
			end
		end
	end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
	logic clk, resetn, nmi, hard_fault, ack, valid;
	logic [6:0] sys_req, number, dma_a;
	logic [27:0] sys_prio;
	logic [64:0] ch_en, single;
	logic [259:0] ch_prio;
	logic [15:0] ext;
	logic [4:0] dma_b, rank;
	logic [1:0] conv, usb1, usb2;
	logic [3:0] can_a, tim1, tim2, can_b, delay;
	logic [31:0] address;
	int seed, n_mismatch, checks, cycles;
	int widths[11] = '{65, 16, 7, 5, 2, 2, 4, 4, 4, 2, 4};

	vectored_interrupt_mapper vectored_interrupt_mapper_i (.CLK_IN(clk), .RESETN_IN(resetn),
		.NMI_IN(nmi), .HARD_FAULT_IN(hard_fault), .SYS_REQ_IN(sys_req),
		.SYS_PRIORITY_IN(sys_prio), .CH_ENABLE_IN(ch_en), .CH_PRIORITY_IN(ch_prio),
		.SINGLE_REQ_IN(single), .EXTERNAL_LINE_REQUEST_IN(ext), .FIRST_DMA_CONTROLLER_IN(dma_a),
		.SECOND_DMA_CONTROLLER_IN(dma_b), .FIRST_SECOND_CONVERTERS_IN(conv),
		.FIRST_USB_DEVICE_IN(usb1), .FIRST_CAN_CONTROLLER_IN(can_a),
		.FIRST_ADVANCED_TIMER_IN(tim1), .SECOND_ADVANCED_TIMER_IN(tim2),
		.SECOND_USB_DEVICE_IN(usb2), .SECOND_CAN_CONTROLLER_IN(can_b), .ACK_IN(ack),
		.REQUEST_VALID_OUT(valid), .EXCEPTION_NUMBER_OUT(number),
		.VECTOR_ADDRESS_OUT(address), .PRIORITY_RANK_OUT(rank));

	core_entry_model core_entry_model_i (.clk_in(clk), .valid_in(valid), .number_in(number),
		.address_in(address), .rank_in(rank), .delay_in(delay), .ack_out(ack));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic go;
		@(posedge clk);
		#1;
	endtask

	task automatic clear_src;
		{nmi, hard_fault, sys_req, single, ext, dma_a, dma_b} = '0;
		{conv, usb1, usb2, can_a, tim1, tim2, can_b} = '0;
	endtask

	// sources were set just after an edge; the next edge samples them
	task automatic strobe;
		go();
		clear_src();
	endtask

	task automatic set_src(input int kind, input int b);
		case (kind)
			0: single[b] = 1'b1;
			1: ext[b] = 1'b1;
			2: dma_a[b] = 1'b1;
			3: dma_b[b] = 1'b1;
			4: conv[b] = 1'b1;
			5: usb1[b] = 1'b1;
			6: can_a[b] = 1'b1;
			7: tim1[b] = 1'b1;
			8: tim2[b] = 1'b1;
			9: usb2[b] = 1'b1;
			default: can_b[b] = 1'b1;
		endcase
	endtask

	function automatic int exp_ch(input int kind, input int b);
		case (kind)
			0: return b;
			1: return (b < 5) ? 6 + b : ((b < 10) ? 23 : 40);
			2: return 11 + b;
			3: return (b < 3) ? 56 + b : 59;
			4: return 18;
			5, 6: return 19 + b;
			7: return 24 + b;
			8: return 43 + b;
			default: return 61 + b;
		endcase
	endfunction

	function automatic logic [4:0] ch_rank(input int ch);
		return {1'b0, ch_prio[4*ch +: 4]} + 5'h03;
	endfunction

	task automatic expect_take(input logic [6:0] slot, input logic [4:0] r);
		int i;
		for (i = 0; i < 1000 && core_entry_model_i.seen_num.size() == 0; i++) go();
		if (core_entry_model_i.seen_num.size() == 0) begin
			check(32'h0, 32'h1);
		end else begin
			check(32'(core_entry_model_i.seen_num.pop_front()), 32'(slot));
			check(core_entry_model_i.seen_addr.pop_front(), {23'h0, slot, 2'b00});
			check(32'(core_entry_model_i.seen_rank.pop_front()), 32'(r));
		end
	endtask

	initial begin
		int k, b, i, j, first;
		seed = 32'hb9dd;
		n_mismatch = 0;
		checks = 0;
		cycles = 0;
		resetn = 1'b0;
		clear_src();
		ch_en = '1;
		delay = 4'h1;
		sys_prio = 28'($random(seed));
		for (k = 0; k < 65; k++) ch_prio[4*k +: 4] = 4'($random(seed));
		repeat (12) @(posedge clk);
		#1 resetn = 1'b1;
		expect_take(7'h01, 5'h00);
		for (k = 0; k < 11; k++) begin
			for (b = 0; b < widths[k]; b++) begin
				if (k == 0 && !vim_pkg::SINGLE_CHANNEL_MASK[b]) continue;
				go();
				delay = ($random(seed) & 1) ? 4'h4 : 4'h1;
				set_src(k, b);
				strobe();
				i = exp_ch(k, b);
				expect_take(7'(16 + i), ch_rank(i));
			end
		end
		for (k = 0; k < 7; k++) begin
			go();
			sys_req[k] = 1'b1;
			strobe();
			expect_take(vim_pkg::SETTABLE_EXC[k], {1'b0, sys_prio[4*k +: 4]} + 5'h03);
		end
		// fixed levels, then programmed rank, then channel number on a tie
		ch_prio[24 +: 4] = 4'h5;
		ch_prio[36 +: 4] = 4'h5;
		ch_prio[160 +: 4] = 4'h2;
		sys_prio[3:0] = 4'h0;
		go();
		{nmi, hard_fault, sys_req[0], ext[0], ext[3], ext[12]} = 6'h3f;
		strobe();
		expect_take(7'h02, 5'h01);
		expect_take(7'h03, 5'h02);
		expect_take(7'h04, 5'h03);
		expect_take(7'h38, 5'h05);
		expect_take(7'h16, 5'h08);
		expect_take(7'h19, 5'h08);
		delay = 4'h4;
		go();
		ext[0] = 1'b1;
		strobe();
		check(32'(valid), 32'h0);
		go();
		check(32'(valid), 32'h1);
		check(32'(number), 32'h16);
		expect_take(7'h16, 5'h08);
		// masked channel stays pending while a higher one is still served
		ch_en[7] = 1'b0;
		ext[1] = 1'b1;
		ext[2] = 1'b1;
		strobe();
		expect_take(7'h18, ch_rank(8));
		repeat (20) go();
		check(32'(core_entry_model_i.seen_num.size()), 32'h0);
		ch_en[7] = 1'b1;
		expect_take(7'h17, ch_rank(7));
		single = ~vim_pkg::SINGLE_CHANNEL_MASK;
		strobe();
		repeat (20) go();
		check(32'(core_entry_model_i.seen_num.size()), 32'h0);
		check(32'(valid), 32'h0);
		// equal levels on channels 0 and 1, then a level held across its own take
		ch_prio[7:4] = ch_prio[3:0];
		single[1:0] = 2'b11;
		strobe();
		expect_take(7'h10, ch_rank(0));
		expect_take(7'h11, ch_rank(1));
		single[0] = 1'b1;
		expect_take(7'h10, ch_rank(0));
		single[0] = 1'b0;
		expect_take(7'h10, ch_rank(0));
		// reset in mid-run: the reset entry comes back first
		resetn = 1'b0;
		go();
		check(32'(valid), 32'h0);
		repeat (2) go();
		resetn = 1'b1;
		expect_take(7'h01, 5'h00);
		for (k = 0; k < 12; k++) begin
			i = {$random(seed)} % 7;
			j = (i + 1 + {$random(seed)} % 6) % 7;
			ch_prio[4*(11+i) +: 4] = 4'({$random(seed)} % 3);
			ch_prio[4*(11+j) +: 4] = 4'({$random(seed)} % 3);
			first = (ch_rank(11 + i) < ch_rank(11 + j) ||
				(ch_rank(11 + i) == ch_rank(11 + j) && i < j)) ? i : j;
			dma_a[i] = 1'b1;
			dma_a[j] = 1'b1;
			strobe();
			expect_take(7'(27 + first), ch_rank(11 + first));
			expect_take(7'(27 + i + j - first), ch_rank(11 + i + j - first));
		end
		tally_and_finish();
	end
endmodule
